// File: aoir_regs.sv
/*
 * Option and local I/O register bank with timer, interrupt capture and routing, wait-line timing and DMA requests.
 * Assumes host bus accesses are single-cycle strobes synchronous to i_ref_clk, decoded by the chip selects.
 */
`timescale 1ns/1ps
// Behaviour
// - Option byte five bit six stores check-status
// - Unused bits ignored on write, read zero
// - Fairness bit reaches arbiter, resets to one
// - Four-bit arbitration level for second request line
// - Local reg zero bit seven drives reset out
// - Local reg zero bit six enables timer
// - I/O wait field applied on I/O cycles
// - Memory wait field applied on memory cycles
// - Wait code seven none, six sync, else async
// - Per-channel burst enable bits, reset zero
// - Per-channel DMA enable bits, reset zero
// - Rising edge of each source latched always
// - Enables gate flags onto mapped host line
// - Timer test bit runs upper nibble only
// - Acknowledge write of one clears flag
// - Status top bit ORs all flags
// - Status bits six to two show flags
// - Count write is reload value at 255
// - Count read returns live counter
// - Combine bit ANDs or ORs requests
// - Software request set, cleared by terminal count
// - Card enable gates interrupt, DMA, wait logic
// - Timer counts at clock over 64, toggles
// - Two-bit route field per external source, timer shares the first, reset 00
// - Active-low check bit drives check output
module aoir_regs #(
   parameter int PRESCALE = aoir_pkg::TIMER_PRESCALE
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_reset,
   input  wire logic                      i_local_register_select_n,
   input  wire logic                      i_option_select_n,
   input  wire aoir_pkg::aoir_bus_type    i_bus,
   input  wire logic                      i_board_select_n,
   input  wire logic                      i_cycle_start,
   input  wire logic                      i_mem_io,
   input  wire logic [4:0]                i_int_src,
   input  wire logic [1:0]                i_dma_hw_req,
   input  wire logic [1:0]                i_dma_owns_bus,
   input  wire logic                      i_terminal_count_n,
   input  wire logic                      i_channel_check_input,
   output logic      [7:0]                o_rdata,
   output logic      [3:0]                o_irq_n,
   output logic                           o_external_reset_output,
   output logic                           o_timer_out,
   output logic                           o_bus_wait_line,
   output logic                           o_card_enable_output,
   output logic                           o_channel_check_n,
   output logic                           o_check_status_present,
   output logic      [1:0]                o_dma_req,
   output aoir_pkg::aoir_dma_cfg_type     o_dma_cfg
);
   // ***********************************************************************
   // Register storage
   // ***********************************************************************
   logic [7:0] ctrl_r;
   logic [1:0] burst_r, dmaen_r, combine_r, swreq_r;
   logic [4:0] int_en_r, flag_r, src_d_r;
   logic       ttest_r;
   logic [7:0] reload_r, count_r;
   logic [7:0] arb_r, route_r;
   logic       chck_n_r, chk_st_r, fair_r;
   logic [3:0] lvl2_r;
   logic [$clog2(PRESCALE)-1:0] pre_r;
   logic [2:0] wait_cnt_r;
   logic       wait_act_r;
   logic       card_enable_output;
   logic       wr_loc, wr_opt, rd_sel;
   logic [7:0] rdata_nxt;
   logic [3:0] irq_nxt;

   function automatic logic [2:0] wait_clocks(input logic [2:0] code);
      // Code 5 holds 2 clocks down to code 0 holding 7
      wait_clocks = 3'(aoir_pkg::WAIT_ASYNC_SUM - int'(code));
   endfunction : wait_clocks

   assign card_enable_output    = arb_r[aoir_pkg::ARB_CEN_BIT];
   assign wr_loc = i_bus.wr && !i_local_register_select_n;
   assign wr_opt = i_bus.wr && !i_option_select_n;
   assign rd_sel = i_bus.rd && !(i_local_register_select_n && i_option_select_n);

   // ***********************************************************************
   // Option bytes
   // ***********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         arb_r    <= aoir_pkg::RST_OPT_ARB;
         route_r  <= aoir_pkg::RST_OPT_ROUTE;
         chck_n_r <= aoir_pkg::RST_OPT_CHECK[aoir_pkg::CHK_CHCK_BIT];
         chk_st_r <= aoir_pkg::RST_OPT_CHECK[aoir_pkg::CHK_STATUS_BIT];
         fair_r   <= aoir_pkg::RST_OPT_CHECK[aoir_pkg::CHK_FAIR_BIT];
         lvl2_r   <= aoir_pkg::RST_OPT_CHECK[3:0];
      end else begin
         if (wr_opt && i_bus.addr == aoir_pkg::ADDR_OPT_ARB) begin
            arb_r <= i_bus.wdata;
         end
         if (wr_opt && i_bus.addr == aoir_pkg::ADDR_OPT_ROUTE) begin
            route_r <= i_bus.wdata;
         end
         if (wr_opt && i_bus.addr == aoir_pkg::ADDR_OPT_CHECK) begin
            chck_n_r <= i_bus.wdata[aoir_pkg::CHK_CHCK_BIT];
            chk_st_r <= i_bus.wdata[aoir_pkg::CHK_STATUS_BIT];
            fair_r   <= i_bus.wdata[aoir_pkg::CHK_FAIR_BIT];
            lvl2_r   <= i_bus.wdata[aoir_pkg::CHK_LEVEL_LSB +: 4];
         end else if (i_channel_check_input) begin
            // External check pulls the bit low; a same-cycle write wins, and a still-high input pulls it low again next cycle
            chck_n_r <= 1'b0;
         end
      end
   end

   // ***********************************************************************
   // Local registers 0, 1, 2 and the timer test bit
   // ***********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ctrl_r   <= aoir_pkg::RST_CTRL_WAIT;
         burst_r  <= '0;
         dmaen_r  <= '0;
         int_en_r <= '0;
         ttest_r  <= 1'b0;
      end else if (wr_loc) begin
         // Only defined bits are stored, so reserved bits can never read back nonzero
         unique case (i_bus.addr)
            aoir_pkg::ADDR_CTRL_WAIT: ctrl_r <= i_bus.wdata;
            aoir_pkg::ADDR_DMA_BURST: begin
               burst_r <= i_bus.wdata[aoir_pkg::BURST_LSB +: 2];
               dmaen_r <= i_bus.wdata[aoir_pkg::DMAEN_LSB +: 2];
            end
            aoir_pkg::ADDR_INT_ENABLE: int_en_r <= i_bus.wdata[aoir_pkg::INT_LSB +: 5];
            aoir_pkg::ADDR_INT_ACK_STS: ttest_r <= i_bus.wdata[aoir_pkg::TTEST_BIT];
            default: ;
         endcase
      end
   end

   // ***********************************************************************
   // Interrupt capture: a new edge wins over a same-cycle acknowledge
   // ***********************************************************************
   logic [4:0] ack, rise;
   assign ack  = (wr_loc && i_bus.addr == aoir_pkg::ADDR_INT_ACK_STS) ?
                 i_bus.wdata[aoir_pkg::INT_LSB +: 5] : 5'h00;
   logic       timer_wrap;
   logic [4:0] src_all;
   assign src_all = {i_int_src[4:1], o_timer_out};
   assign rise    = src_all & ~src_d_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         src_d_r <= '0;
         flag_r  <= '0;
      end else begin
         src_d_r <= src_all;
         flag_r  <= (flag_r & ~ack) | rise;
      end
   end

   // ***********************************************************************
   // Timer
   // ***********************************************************************
   logic pre_tick;
   assign pre_tick   = pre_r == ($clog2(PRESCALE))'(PRESCALE - 1);
   // Gated by the enable so a stopped prescaler parked on its last count never fakes a wrap
   assign timer_wrap = ctrl_r[aoir_pkg::CTRL_TIMER_BIT] && pre_tick &&
                       (ttest_r ? count_r[7:4] == 4'hf : count_r == aoir_pkg::TIMER_TOP);

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pre_r       <= '0;
         count_r     <= '0;
         reload_r    <= '0;
         o_timer_out <= 1'b0;
      end else begin
         if (wr_loc && i_bus.addr == aoir_pkg::ADDR_TIMER_COUNT) begin
            reload_r <= i_bus.wdata;
         end
         if (ctrl_r[aoir_pkg::CTRL_TIMER_BIT]) begin
            pre_r <= pre_tick ? '0 : pre_r + 1'b1;
            if (timer_wrap) begin
               count_r     <= reload_r;
               o_timer_out <= ~o_timer_out;
            end else if (pre_tick) begin
               // Test mode steps the upper nibble directly
               count_r <= ttest_r ? count_r + 8'h10 : count_r + 8'h01;
            end
         end
      end
   end

   // ***********************************************************************
   // Software DMA requests and combine bits
   // ***********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         combine_r <= '0;
         swreq_r   <= '0;
      end else begin
         if (wr_loc && i_bus.addr == aoir_pkg::ADDR_SW_DMA_REQ) begin
            combine_r <= i_bus.wdata[aoir_pkg::COMBINE_LSB +: 2];
            swreq_r   <= i_bus.wdata[aoir_pkg::SWREQ_LSB +: 2];
         end
         if (!i_terminal_count_n) begin
            swreq_r <= swreq_r & ~i_dma_owns_bus;
         end
         if (!card_enable_output) begin
            combine_r <= '0;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_dma_req <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            o_dma_req[c] <= card_enable_output && dmaen_r[c] &&
                            (combine_r[c] ? (swreq_r[c] & i_dma_hw_req[c]) : (swreq_r[c] | i_dma_hw_req[c]));
         end
      end
   end

   // ***********************************************************************
   // Wait-line generator; active high means not ready
   // ***********************************************************************
   logic [2:0] wcode;
   assign wcode = i_mem_io ? ctrl_r[aoir_pkg::CTRL_MEMWAIT_LSB +: 3] :
                             ctrl_r[aoir_pkg::CTRL_IOWAIT_LSB +: 3];

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         wait_cnt_r <= '0;
         wait_act_r <= 1'b0;
      end else if (i_cycle_start && !i_board_select_n && card_enable_output && wcode != aoir_pkg::WAIT_NONE) begin
         wait_act_r <= 1'b1;
         // Synchronous extension holds one clock; asynchronous codes hold the decoded count
         wait_cnt_r <= (wcode == aoir_pkg::WAIT_SYNC) ? 3'h1 : wait_clocks(wcode);
      end else if (wait_act_r) begin
         wait_cnt_r <= wait_cnt_r - 3'h1;
         // Dropping card enable abandons a running wait
         wait_act_r <= card_enable_output && wait_cnt_r != 3'h1;
      end
   end
   assign o_bus_wait_line = wait_act_r;

   // ***********************************************************************
   // Interrupt routing and read mux
   // ***********************************************************************
   always_comb begin
      irq_nxt = '0;
      for (int s = 0; s < 5; s++) begin
         if (card_enable_output && int_en_r[s] && flag_r[s]) begin
            // The timer shares the first external source's route field; there is no fifth field
            irq_nxt[route_r[((s == 0) ? 0 : 2*(s-1)) +: 2]] = 1'b1;
         end
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      unique case ({i_local_register_select_n, i_option_select_n, i_bus.addr})
         {2'b01, aoir_pkg::ADDR_CTRL_WAIT}:   rdata_nxt = ctrl_r;
         {2'b01, aoir_pkg::ADDR_DMA_BURST}:   rdata_nxt = {2'b00, burst_r, 2'b00, dmaen_r};
         {2'b01, aoir_pkg::ADDR_INT_ENABLE}:  rdata_nxt = {1'b0, int_en_r, 2'b00};
         {2'b01, aoir_pkg::ADDR_INT_ACK_STS}: rdata_nxt = {|flag_r, flag_r, 2'b00};
         {2'b01, aoir_pkg::ADDR_TIMER_COUNT}: rdata_nxt = count_r;
         {2'b01, aoir_pkg::ADDR_SW_DMA_REQ}:  rdata_nxt = {combine_r, 4'h0, swreq_r};
         {2'b10, aoir_pkg::ADDR_OPT_ARB}:     rdata_nxt = arb_r;
         {2'b10, aoir_pkg::ADDR_OPT_ROUTE}:   rdata_nxt = route_r;
         {2'b10, aoir_pkg::ADDR_OPT_CHECK}:   rdata_nxt = {chck_n_r, chk_st_r, 1'b0, fair_r, lvl2_r};
         default:                             rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rdata                 <= '0;
         o_irq_n                 <= 4'hf;
         o_external_reset_output <= 1'b0;
         o_card_enable_output    <= 1'b0;
         o_channel_check_n       <= 1'b1;
         o_check_status_present  <= 1'b0;
         o_dma_cfg               <= '0;
      end else begin
         o_rdata                 <= rd_sel ? rdata_nxt : 8'h00;
         o_irq_n                 <= ~irq_nxt;
         o_external_reset_output <= ctrl_r[aoir_pkg::CTRL_SWRST_BIT];
         o_card_enable_output    <= card_enable_output;
         o_channel_check_n       <= chck_n_r;
         o_check_status_present  <= chk_st_r;
         o_dma_cfg <= '{local_arbiter_enable: arb_r[aoir_pkg::ARB_LOCAL_ARBITER_ENABLE_BIT],
                        strobe_mode_select:   arb_r[aoir_pkg::ARB_STROBE_BIT],
                        sync_burst_release:   arb_r[aoir_pkg::ARB_SYNCB_BIT],
                        arb_level_one:        arb_r[aoir_pkg::ARB_LEVEL_LSB +: 4],
                        arb_level_two:        lvl2_r,
                        fairness:             fair_r,
                        burst_en:             burst_r & {2{card_enable_output}},
                        dma_en:               dmaen_r & {2{card_enable_output}}};
      end
   end

   // ***********************************************************************
   // Checks
   // ***********************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   chk_fair_reset: assert property ($fell(i_reset) |-> fair_r)
      else $error("fairness not one after reset");
   chk_rst_out: assert property (wr_loc && i_bus.addr == aoir_pkg::ADDR_CTRL_WAIT |=> ##1
                                 o_external_reset_output == $past(i_bus.wdata[7], 2))
      else $error("reset output does not follow bit seven");
   chk_edge_latch: assert property (rise[1] |=> flag_r[1])
      else $error("rising edge not latched");
   chk_ack_clear: assert property (ack[2] && !rise[2] |=> !flag_r[2])
      else $error("acknowledge did not clear flag");
   chk_status_or: assert property (rd_sel && !i_local_register_select_n && i_bus.addr == aoir_pkg::ADDR_INT_ACK_STS
                                   |=> o_rdata[7] == |$past(flag_r) && o_rdata[1:0] == 2'b00)
      else $error("status read wrong");
   chk_irq_gate: assert property (int_en_r == 5'h00 |=> o_irq_n == 4'hf)
      else $error("disabled interrupt reached host line");
   chk_timer_reload: assert property (timer_wrap |=> count_r == $past(reload_r))
      else $error("timer did not reload");
   chk_tc_clear: assert property (!i_terminal_count_n && i_dma_owns_bus[0] && !wr_loc |=> !swreq_r[0])
      else $error("software request not cleared by terminal count");
   chk_cen_gate: assert property (!card_enable_output |=> o_dma_req == 2'b00 && !wait_act_r)
      else $error("card disabled but logic active");
   chk_wait_async: assert property (i_cycle_start && !i_board_select_n && card_enable_output && wcode == 3'h5 && !wait_act_r
                                    |=> wait_act_r [*2] ##1 !wait_act_r)
      else $error("async wait length wrong");

   cov_timer_wrap: cover property (timer_wrap);
   cov_irq_raise:  cover property ($fell(o_irq_n[0]));
   cov_wait_run:   cover property ($rose(wait_act_r));
   cov_sw_dma:     cover property ($rose(o_dma_req[1]));
endmodule : aoir_regs

// File: aoir_pkg.sv
/*
 * Package for the adapter option and local I/O register bank.
 * Holds the register offsets, field positions, reset values, timer counts and the carrier structs.
 * Assumes a single clock and byte-wide host accesses.
 */
package aoir_pkg;
   // **********************************************************************
   // Register offsets (option bytes carry the 0x100 page)
   // **********************************************************************
   localparam logic [8:0] ADDR_CTRL_WAIT   = 9'h000;
   localparam logic [8:0] ADDR_DMA_BURST   = 9'h001;
   localparam logic [8:0] ADDR_INT_ENABLE  = 9'h002;
   localparam logic [8:0] ADDR_INT_ACK_STS = 9'h003;
   localparam logic [8:0] ADDR_TIMER_COUNT = 9'h004;
   localparam logic [8:0] ADDR_SW_DMA_REQ  = 9'h005;
   localparam logic [8:0] ADDR_OPT_ARB     = 9'h102;
   localparam logic [8:0] ADDR_OPT_ROUTE   = 9'h104;
   localparam logic [8:0] ADDR_OPT_CHECK   = 9'h105;

   // **********************************************************************
   // Field positions
   // **********************************************************************
   localparam int CTRL_SWRST_BIT   = 7;
   localparam int CTRL_TIMER_BIT   = 6;
   localparam int CTRL_IOWAIT_LSB  = 3;
   localparam int CTRL_MEMWAIT_LSB = 0;
   localparam int BURST_LSB        = 4;
   localparam int DMAEN_LSB        = 0;
   localparam int INT_LSB          = 2;
   localparam int TTEST_BIT        = 7;
   localparam int ANYINT_BIT       = 7;
   localparam int COMBINE_LSB      = 6;
   localparam int SWREQ_LSB        = 0;
   localparam int ARB_LOCAL_ARBITER_ENABLE_BIT    = 7;
   localparam int ARB_STROBE_BIT   = 6;
   localparam int ARB_SYNCB_BIT    = 5;
   localparam int ARB_LEVEL_LSB    = 1;
   localparam int ARB_CEN_BIT      = 0;
   localparam int CHK_CHCK_BIT     = 7;
   localparam int CHK_STATUS_BIT   = 6;
   localparam int CHK_FAIR_BIT     = 4;
   localparam int CHK_LEVEL_LSB    = 0;

   // **********************************************************************
   // Reset values and timing counts
   // **********************************************************************
   localparam logic [7:0] RST_CTRL_WAIT  = 8'h00;
   localparam logic [7:0] RST_OPT_ARB    = 8'h00;
   localparam logic [7:0] RST_OPT_ROUTE  = 8'h00;
   localparam logic [7:0] RST_OPT_CHECK  = 8'h90;
   localparam logic [7:0] TIMER_TOP      = 8'hff;
   localparam int         TIMER_PRESCALE = 64;
   localparam logic [2:0] WAIT_NONE      = 3'h7;
   localparam logic [2:0] WAIT_SYNC      = 3'h6;
   localparam int         WAIT_ASYNC_SUM = 7;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [8:0] addr;
      logic [7:0] wdata;
   } aoir_bus_type;

   typedef struct packed {
      logic       local_arbiter_enable;
      logic       strobe_mode_select;
      logic       sync_burst_release;
      logic [3:0] arb_level_one;
      logic [3:0] arb_level_two;
      logic       fairness;
      logic [1:0] burst_en;
      logic [1:0] dma_en;
   } aoir_dma_cfg_type;
endpackage : aoir_pkg

// File: aoir_periph_model.sv
/*
 * Behavioural model of the adapter peripheral logic next to the register bank.
 * Assumes the bench calls its tasks; all outputs change by non-blocking assignment at rising edges.
 */
`timescale 1ns/1ps
module aoir_periph_model (
   input  wire logic       i_ref_clk,
   output logic      [4:0] o_int_src,
   output logic      [1:0] o_dma_hw_req,
   output logic      [1:0] o_owns_bus,
   output logic            o_terminal_count_n,
   output logic            o_channel_check_input
);
   // ************************************************************
   // Idle levels at time zero
   // ************************************************************
   initial begin
      o_int_src             = 5'h00;
      o_dma_hw_req          = 2'h0;
      o_owns_bus            = 2'h0;
      o_terminal_count_n    = 1'b1;
      o_channel_check_input = 1'b0;
   end

   // Short level pulse; only its rising edge matters to the bank
   task automatic raise_int(input int idx);
      @(posedge i_ref_clk) o_int_src[idx] <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      o_int_src[idx] <= 1'b0;
   endtask : raise_int

   task automatic set_hw_req(input logic [1:0] v);
      @(posedge i_ref_clk) o_dma_hw_req <= v;
   endtask : set_hw_req

   // Terminal count only while the channel holds the bus
   task automatic finish_dma(input int ch);
      @(posedge i_ref_clk) o_owns_bus[ch] <= 1'b1;
      @(posedge i_ref_clk) o_terminal_count_n <= 1'b0;
      @(posedge i_ref_clk) o_terminal_count_n <= 1'b1;
      o_owns_bus <= 2'h0;
   endtask : finish_dma
endmodule : aoir_periph_model

// File: adapter_option_io_registers_test.sv
/*
 * Self-checking bench for the option and local register bank.
 * Assumes single-cycle bus strobes and a timer prescale shortened to 4.
 */
`timescale 1ns/1ps
module adapter_option_io_registers_test;
   logic                   i_ref_clk = 1'b0;
   logic                   i_reset   = 1'b1;
   logic                   lrs_n     = 1'b1;
   logic                   opt_n     = 1'b1;
   aoir_pkg::aoir_bus_type bus       = '0;
   logic                   board_select_n    = 1'b1;
   logic                   cyc_start = 1'b0;
   logic                   mem_io    = 1'b0;
   logic [4:0]             int_src;
   logic [1:0]             hw_req, owns;
   logic                   tc_n, chk_in;
   logic [7:0]             rdata;
   logic [3:0]             irq_n;
   logic                   rst_out, tim_out, wait_ln, card_enable_output, chk_n, chk_st;
   logic [1:0]             dma_req;
   aoir_pkg::aoir_dma_cfg_type dma_cfg;
   int                     err_count   = 0;
   int                     comparisons = 0;

   always #2 i_ref_clk = ~i_ref_clk;

   aoir_periph_model peri (.i_ref_clk(i_ref_clk), .o_int_src(int_src), .o_dma_hw_req(hw_req),
      .o_owns_bus(owns), .o_terminal_count_n(tc_n), .o_channel_check_input(chk_in));

   aoir_regs #(.PRESCALE(4)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_local_register_select_n(lrs_n), .i_option_select_n(opt_n), .i_bus(bus),
      .i_board_select_n(board_select_n), .i_cycle_start(cyc_start), .i_mem_io(mem_io), .i_int_src(int_src),
      .i_dma_hw_req(hw_req), .i_dma_owns_bus(owns), .i_terminal_count_n(tc_n),
      .i_channel_check_input(chk_in), .o_rdata(rdata), .o_irq_n(irq_n), .o_external_reset_output(rst_out),
      .o_timer_out(tim_out), .o_bus_wait_line(wait_ln), .o_card_enable_output(card_enable_output),
      .o_channel_check_n(chk_n), .o_check_status_present(chk_st), .o_dma_req(dma_req), .o_dma_cfg(dma_cfg));

   // ************************************************************
   // Compare, bus access, wait-line and timer helpers
   // ************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      bus   <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      lrs_n <= a[8];
      opt_n <= ~a[8];
      @(posedge i_ref_clk);
      bus   <= '0;
      lrs_n <= 1'b1;
      opt_n <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
   endtask : wr

   // Read data stands one cycle only, so it is sampled just after that edge
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      bus   <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      lrs_n <= a[8];
      opt_n <= ~a[8];
      @(posedge i_ref_clk);
      bus   <= '0;
      lrs_n <= 1'b1;
      opt_n <= 1'b1;
      #1 check(rdata, exp, "read data");
   endtask : rd

   task automatic wait_len(input logic mem, input int exp);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      cyc_start <= 1'b1;
      board_select_n    <= 1'b0;
      mem_io    <= mem;
      @(posedge i_ref_clk) cyc_start <= 1'b0;
      repeat (10) begin
         #1 n += (wait_ln === 1'b1);
         @(posedge i_ref_clk);
      end
      board_select_n <= 1'b1;
      check(8'(n), 8'(exp), "wait clocks");
   endtask : wait_len

   // Half period of the square wave in clocks, from a rising edge of the timer output
   task automatic high_len(input logic [7:0] exp);
      int n;
      n = 0;
      @(posedge tim_out);
      while (tim_out === 1'b1 && n < 40) begin
         @(posedge i_ref_clk) #1 n++;
      end
      check(8'(n), exp, "timer half period");
   endtask : high_len

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(aoir_pkg::ADDR_OPT_CHECK, 8'h90);
      rd(aoir_pkg::ADDR_OPT_ARB, 8'h00);
      rd(aoir_pkg::ADDR_CTRL_WAIT, 8'h00);
      rd(aoir_pkg::ADDR_INT_ENABLE, 8'h00);
      $display("reset values done");
      wr(aoir_pkg::ADDR_DMA_BURST, 8'hff);
      rd(aoir_pkg::ADDR_DMA_BURST, 8'h33);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h80);
      check(8'(rst_out), 8'h01, "reset out");
      rd(aoir_pkg::ADDR_OPT_CHECK, 8'h90);
      wr(aoir_pkg::ADDR_OPT_CHECK, 8'h5a);
      check({6'h00, chk_n, chk_st}, 8'h01, "check low");
      wr(aoir_pkg::ADDR_OPT_CHECK, 8'hda);
      check({6'h00, chk_n, chk_st}, 8'h03, "check cleared");
      rd(aoir_pkg::ADDR_OPT_CHECK, 8'hda);
      $display("register access done");
      wr(aoir_pkg::ADDR_OPT_ARB, 8'h01);
      check(8'(card_enable_output), 8'h01, "card enable");
      check({dma_cfg.burst_en, dma_cfg.dma_en, dma_cfg.arb_level_two}, 8'hfa, "dma config");
      check({dma_cfg.fairness, 3'h0, dma_cfg.arb_level_one}, 8'h80, "arbitration config");
      wr(aoir_pkg::ADDR_OPT_ROUTE, 8'h0c);
      wr(aoir_pkg::ADDR_INT_ENABLE, 8'h08);
      peri.raise_int(2);
      repeat (3) @(posedge i_ref_clk);
      rd(aoir_pkg::ADDR_INT_ACK_STS, 8'h90);
      check(8'(irq_n), 8'h0f, "masked source");
      peri.raise_int(1);
      repeat (3) @(posedge i_ref_clk);
      check(8'(irq_n), 8'h0e, "routed line");
      wr(aoir_pkg::ADDR_INT_ACK_STS, 8'h08);
      rd(aoir_pkg::ADDR_INT_ACK_STS, 8'h90);
      check(8'(irq_n), 8'h0f, "acknowledged line");
      wr(aoir_pkg::ADDR_INT_ACK_STS, 8'h10);
      rd(aoir_pkg::ADDR_INT_ACK_STS, 8'h00);
      $display("interrupt test done");
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h3f);
      wait_len(1'b1, 0);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h3e);
      wait_len(1'b1, 1);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h3d);
      wait_len(1'b1, 2);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h38);
      wait_len(1'b1, 7);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h27);
      wait_len(1'b0, 3);
      wait_len(1'b1, 0);
      $display("wait state test done");
      wr(aoir_pkg::ADDR_SW_DMA_REQ, 8'h01);
      check(8'(dma_req), 8'h01, "or request");
      wr(aoir_pkg::ADDR_SW_DMA_REQ, 8'h41);
      check(8'(dma_req), 8'h00, "and request");
      peri.set_hw_req(2'h1);
      repeat (3) @(posedge i_ref_clk);
      check(8'(dma_req), 8'h01, "and both");
      peri.finish_dma(0);
      repeat (2) @(posedge i_ref_clk);
      rd(aoir_pkg::ADDR_SW_DMA_REQ, 8'h40);
      $display("dma request test done");
      // Reload 0xfd gives three prescaled ticks of 4 clocks per half period
      wr(aoir_pkg::ADDR_TIMER_COUNT, 8'hfd);
      wr(aoir_pkg::ADDR_CTRL_WAIT, 8'h7f);
      rd(aoir_pkg::ADDR_TIMER_COUNT, 8'h00);
      high_len(8'h0c);
      rd(aoir_pkg::ADDR_INT_ACK_STS, 8'h84);
      wr(aoir_pkg::ADDR_INT_ENABLE, 8'h04);
      check(8'(irq_n), 8'h0e, "timer line");
      wr(aoir_pkg::ADDR_INT_ACK_STS, 8'h80);
      high_len(8'h04);
      $display("timer test done");
      tally_and_finish();
   end

   // Whole run is about 1250 cycles; this leaves wide margin
   initial begin
      #40000;
      err_count++;
      tally_and_finish();
   end
endmodule : adapter_option_io_registers_test
